// ==== tb/cdc_i2c_slave_register_port_tb.sv ====
`timescale 1ns/1ps
`include "cdc_i2c_defs.svh"
module cdc_i2c_slave_register_port_tb;
  localparam int RELOAD = 3000;
  // arbitrary value
  localparam logic [7:0] CHIP = 8'hC3;
  // arbitrary value
  localparam logic [31:0] SERIAL = 32'h89AB_CDEF;
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] data;
    logic [7:0] rd;
    logic       stored;
  } row_s;

  logic                    clk = 1'b0;
  logic                    link_clk = 1'b0;
  logic                    reset = 1'b1;
  logic                    scl;
  logic                    sda_drv;
  logic                    sda_out;
  logic                    sda_oe_n;
  logic                    reload_busy;
  logic                    wr_valid;
  cdc_i2c_pkg::reg_write_s wr_word;
  cdc_i2c_pkg::reg_write_s last_word;
  wire logic               sda_line;
  int                      error_cnt = 0;
  int                      n_compared = 0;
  int                      n_wr = 0;
  int                      busy_len = 0;
  int                      k;
  logic                    ack;
  logic [7:0]              got [0:7];
  row_s                    rows [0:5];

  always #5 clk = ~clk;
  // 3 ns offset keeps link edges off the negedge stimulus edges; every fifth link edge still lands on a posedge clk
  initial begin
    #3;
    forever #16 link_clk = ~link_clk;
  end
  assign sda_line = sda_drv & (sda_oe_n | sda_out);

  cdc_i2c_slave_register_port #(
    .RELOAD_CYCLES (RELOAD),
    .CHIP_IDENTIFICATION       (CHIP),
    .SERIAL_NUMBER (SERIAL)
  ) DUT (
    .clk         (clk),
    .reset       (reset),
    .link_clk    (link_clk),
    .scl_in      (scl),
    .sda_in      (sda_line),
    .sda_out     (sda_out),
    .sda_oe_n    (sda_oe_n),
    .reload_busy (reload_busy),
    .wr_valid    (wr_valid),
    .wr_word     (wr_word)
  );

  i2c_master_model #(
    .Q (14)
  ) m (
    .clk      (clk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_drv  (sda_drv)
  );

  always @(posedge clk) begin
    if (wr_valid === 1'b1) begin
      n_wr <= n_wr + 1;
      last_word <= wr_word;
    end
  end

  // busy cycles in core cycles, summed over all reload windows
  always @(posedge clk) begin
    if (reload_busy === 1'b1) begin
      busy_len <= busy_len + 1;
    end
  end

  task automatic chk8(input string name, input logic [7:0] exp,
                      input logic [7:0] seen);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic seen);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", name, exp, seen);
    end
  endtask

  task automatic put(input logic [7:0] d, input logic exp);
    m.send_byte(d, ack);
    chk1("ack", exp, ack);
  endtask

  // n bytes d, d+1, ... from pointer p
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d,
                        input int n);
    m.start_cond();
    put(`DEV_ADDR_WR, 1'b1);
    put(p, 1'b1);
    for (int i = 0; i < n; i++) begin
      put(d + 8'(i), 1'b1);
    end
    m.stop_cond();
    m.pause(10);
  endtask

  task automatic rd_regs(input logic [7:0] p, input int n);
    m.start_cond();
    put(`DEV_ADDR_WR, 1'b1);
    put(p, 1'b1);
    m.start_cond();
    put(`DEV_ADDR_RD, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.recv_byte(i < n - 1, got[i]);
    end
    m.stop_cond();
  endtask

  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // whole run needs roughly 55k cycles
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    rows[0] = '{8'h05, 8'hAB, 8'hAB, 1'b1};
    rows[1] = '{`REG_WR_FIRST, 8'h11, 8'h11, 1'b1};
    rows[2] = '{`REG_WR_LAST, 8'h3C, 8'h3C, 1'b1};
    rows[3] = '{8'h00, 8'h77, 8'h00, 1'b0};
    rows[4] = '{`REG_CHIP_IDENTIFICATION, 8'hEE, CHIP, 1'b0};
    rows[5] = '{`REG_SERIAL_FIRST, 8'h99, SERIAL[31:24], 1'b0};
    repeat (12) @(negedge clk);
    chk1("sda_oe_n", 1'b1, sda_oe_n);
    chk1("reload_busy", 1'b0, reload_busy);
    chk1("wr_valid", 1'b0, wr_valid);
    reset = 1'b0;
    m.pause(20);
    rd_regs(`REG_PD_TIMER, 2);
    chk8("pd_timer", `PD_TIMER_RESET, got[0]);
    chk8("capdac", `CAPDAC_RESET, got[1]);
    // stop must have pulled the pointer back from 0x11
    m.start_cond();
    put(`DEV_ADDR_RD, 1'b1);
    m.recv_byte(1'b0, got[0]);
    m.stop_cond();
    chk8("after_stop", `OTHER_RESET, got[0]);
    m.start_cond();
    put(8'h92, 1'b0);
    m.stop_cond();
    for (int r = 0; r < 6; r++) begin
      k = n_wr;
      wr_reg(rows[r].ptr, rows[r].data, 1);
      chk1("stored", rows[r].stored, n_wr == k + 1);
      if (rows[r].stored) begin
        chk8("wr_addr", rows[r].ptr, last_word.addr);
        chk8("wr_data", rows[r].data, last_word.data);
      end
      rd_regs(rows[r].ptr, 1);
      chk8("readback", rows[r].rd, got[0]);
    end
    k = n_wr;
    wr_reg(8'h07, 8'hA1, 2);
    chk1("burst", 1'b1, n_wr == k + 2);
    chk8("burst_addr", 8'h08, last_word.addr);
    rd_regs(8'h07, 2);
    chk8("burst0", 8'hA1, got[0]);
    chk8("burst1", 8'hA2, got[1]);
    rd_regs(8'h15, 4);
    chk8("serial2", SERIAL[15:8], got[0]);
    chk8("serial3", SERIAL[7:0], got[1]);
    chk8("chip_identification", CHIP, got[2]);
    chk8("beyond", 8'h00, got[3]);
    m.start_cond();
    put(`GCALL_ADDR, 1'b1);
    put(8'h07, 1'b0);
    m.stop_cond();
    for (int kind = 0; kind < 2; kind++) begin
      wr_reg(`REG_CAPDAC, 8'h00, 1);
      k = busy_len;
      m.start_cond();
      put(kind ? `GCALL_ADDR : `DEV_ADDR_WR, 1'b1);
      put(kind ? `GCALL_RESET : `RESET_CMD_PTR, 1'b1);
      m.stop_cond();
      chk1("reload_busy", 1'b1, reload_busy);
      m.start_cond();
      put(`DEV_ADDR_WR, 1'b0);
      m.stop_cond();
      for (int t = 0; t < 2 * RELOAD && reload_busy !== 1'b0; t++) begin
        @(negedge clk);
      end
      chk1("reload_done", 1'b0, reload_busy);
      chk1("busy_len", 1'b1, busy_len == k + RELOAD);
      m.pause(40);
      rd_regs(`REG_CAPDAC, 1);
      chk8("reloaded", `CAPDAC_RESET, got[0]);
    end
    give_verdict();
  end
endmodule

// ==== tb/i2c_master_model.sv ====
`timescale 1ns/1ps
module i2c_master_model #(
  parameter int Q = 14
) (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  // released lines idle high through the pull-ups
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic start_cond();
    pause(Q);
    sda_drv = 1'b1;
    pause(Q);
    scl = 1'b1;
    pause(2 * Q);
    sda_drv = 1'b0;
    pause(2 * Q);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    pause(Q);
    sda_drv = 1'b0;
    pause(Q);
    scl = 1'b1;
    pause(2 * Q);
    sda_drv = 1'b1;
    pause(2 * Q);
  endtask

  // data moves only mid-low; sampled mid-high
  task automatic bit_cycle(input logic b, output logic r);
    pause(Q);
    sda_drv = b;
    pause(Q);
    scl = 1'b1;
    pause(Q);
    r = sda_line;
    pause(Q);
    scl = 1'b0;
  endtask

  // eight bits msb first, then ack slot
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(d[i], r);
    end
    bit_cycle(1'b1, r);
    ack = ~r;
  endtask

  // msb first, ack or no-ack from master
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, r);
      d[i] = r;
    end
    bit_cycle(~ack, r);
  endtask
endmodule

// ==== verilog/cdc_i2c_defs.svh ====
`ifndef CDC_I2C_DEFS_SVH
`define CDC_I2C_DEFS_SVH

`define DEV_ADDR_WR       8'h90
`define DEV_ADDR_RD       8'h91
`define GCALL_ADDR        8'h00
`define GCALL_RESET       8'h06
`define RESET_CMD_PTR     8'hBF
`define PTR_RESET         8'h00

`define REG_PD_TIMER      8'h10
`define REG_CAPDAC        8'h11
`define REG_SERIAL_FIRST  8'h13
`define REG_SERIAL_LAST   8'h16
`define REG_CHIP_IDENTIFICATION       8'h17
`define REG_WR_FIRST      8'h01
`define REG_WR_LAST       8'h12
`define REG_FILE_DEPTH    32

`define PD_TIMER_RESET    8'h00
`define CAPDAC_RESET      8'hC0
`define OTHER_RESET       8'h00

`define BYTE_BITS         4'h8
`define CLK_MHZ           100
`define RELOAD_TIME_US    2000
`define RELOAD_CYCLES     (`RELOAD_TIME_US * `CLK_MHZ)

`endif

// ==== verilog/cdc_i2c_pkg.sv ====
package cdc_i2c_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_ACK   = 3'h3,
    ST_PTR   = 3'h2,
    ST_WDATA = 3'h6,
    ST_TX    = 3'h7,
    ST_MACK  = 3'h5,
    ST_GCALL = 3'h4
  } link_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_s;

endpackage

// ==== verilog/cdc_i2c_slave_register_port.sv ====
`timescale 1ns/1ps
`include "cdc_i2c_defs.svh"
// Functional notes
// - first byte is 7-bit address plus direction bit, MSB first
// - matching address acknowledged on ninth pulse, else bus released, idle
// - direction 0 makes a write receiver, 1 a read transmitter
// - address byte 0x90 answers writes, 0x91 answers reads
// - read sends register selected by pointer, then awaits master ack
// - master ack advances pointer; missing ack goes idle, pointer kept
// - pointer value itself is never readable, only selected contents
// - reads past valid registers return internal contents up to 0x1F, then 0x00
// - stop ending a read resets pointer to status register 0x00
// - write to invalid address is dropped but still acknowledged
// - first byte of a write loads the pointer and is acknowledged
// - stop returns to idle and resets pointer to 0x00
// - data bytes stored, acknowledged, pointer advances each byte
// - repeated start handled exactly like a start
// - pointer value 0xBF reloads every register default
// - no acknowledge for about 2 ms while defaults reload
// - general call address acknowledged and next byte accepted
// - general call byte 0x06 reloads defaults but does not reset the pointer
// - any other general call byte is not acknowledged
// - read-only 8-bit identification register at pointer 0x17
module cdc_i2c_slave_register_port #(
  parameter int          RELOAD_CYCLES = `RELOAD_CYCLES,
  // arbitrary value
  parameter logic [7:0]  CHIP_IDENTIFICATION       = 8'h5A,
  // arbitrary value
  parameter logic [31:0] SERIAL_NUMBER = 32'h0123_4567
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              link_clk,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe_n,
  output logic                   reload_busy,
  output logic                   wr_valid,
  output cdc_i2c_pkg::reg_write_s wr_word
);

  logic                     link_rst_meta;
  logic                     link_rst;
  logic [1:0]               pin_meta;
  logic [1:0]               pin_sync;
  logic [1:0]               pin_hist;
  logic                     scl_f;
  logic                     sda_f;
  logic                     scl_prev;
  logic                     sda_prev;
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     start_det;
  logic                     stop_det;
  cdc_i2c_pkg::link_state_e state;
  cdc_i2c_pkg::link_state_e after_ack;
  cdc_i2c_pkg::link_state_e next_after;
  logic [3:0]               bit_cnt;
  logic [7:0]               rx_shift;
  logic [7:0]               tx_shift;
  logic [7:0]               ptr;
  logic                     mack_ok;
  logic                     decide;
  logic                     ack_now;
  logic                     reload_now;
  logic                     reg_wr;
  logic [7:0]               read_val;
  logic                     read_msb;
  logic [7:0]               reg_file [`REG_FILE_DEPTH];
  logic                     link_wait;
  logic                     busy_meta;
  logic                     busy_sync;
  logic                     busy_link;
  logic                     reload_tgl;
  logic                     wr_tgl;
  cdc_i2c_pkg::reg_write_s  wr_hold;
  logic [2:0]               reload_sync;
  logic [2:0]               wr_sync;
  logic                     reload_edge;
  logic                     wr_edge;
  logic [17:0]              reload_cnt;

  // open drain: only ever pulls low
  assign sda_out = 1'b0;

  always_ff @(posedge link_clk) begin
    link_rst_meta <= reset;
    link_rst      <= link_rst_meta;
  end

  always_ff @(posedge link_clk) begin
    pin_meta <= {scl_in, sda_in};
    pin_sync <= pin_meta;
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      pin_hist <= 2'h3;
      scl_f    <= 1'b1;
      sda_f    <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      pin_hist <= pin_sync;
      if (pin_hist[1] == pin_sync[1]) begin
        scl_f <= pin_sync[1];
      end
      if (pin_hist[0] == pin_sync[0]) begin
        sda_f <= pin_sync[0];
      end
      scl_prev <= scl_f;
      sda_prev <= sda_f;
    end
  end

  assign scl_rise  = scl_f & ~scl_prev;
  assign scl_fall  = ~scl_f & scl_prev;
  // start and stop from filtered samples
  assign start_det = scl_f & scl_prev & sda_prev & ~sda_f;
  assign stop_det  = scl_f & scl_prev & ~sda_prev & sda_f;

  assign busy_link = link_wait | busy_sync;
  assign decide    = scl_fall && (bit_cnt == `BYTE_BITS) &&
                     (state == cdc_i2c_pkg::ST_ADDR ||
                      state == cdc_i2c_pkg::ST_PTR ||
                      state == cdc_i2c_pkg::ST_WDATA ||
                      state == cdc_i2c_pkg::ST_GCALL);

  always_comb begin
    ack_now    = 1'b0;
    next_after = cdc_i2c_pkg::ST_IDLE;
    unique case (state)
      cdc_i2c_pkg::ST_ADDR: begin
        if (!busy_link) begin
          if (rx_shift == `DEV_ADDR_WR) begin
            ack_now    = 1'b1;
            next_after = cdc_i2c_pkg::ST_PTR;
          end else if (rx_shift == `DEV_ADDR_RD) begin
            ack_now    = 1'b1;
            next_after = cdc_i2c_pkg::ST_TX;
          end else if (rx_shift == `GCALL_ADDR) begin
            ack_now    = 1'b1;
            next_after = cdc_i2c_pkg::ST_GCALL;
          end
        end
      end
      cdc_i2c_pkg::ST_PTR: begin
        ack_now = 1'b1;
        if (rx_shift != `RESET_CMD_PTR) begin
          next_after = cdc_i2c_pkg::ST_WDATA;
        end
      end
      cdc_i2c_pkg::ST_WDATA: begin
        ack_now    = 1'b1;
        next_after = cdc_i2c_pkg::ST_WDATA;
      end
      cdc_i2c_pkg::ST_GCALL: begin
        // only the reset code is acked
        ack_now = (rx_shift == `GCALL_RESET);
      end
      cdc_i2c_pkg::ST_IDLE,
      cdc_i2c_pkg::ST_ACK,
      cdc_i2c_pkg::ST_TX,
      cdc_i2c_pkg::ST_MACK: begin
        ack_now = 1'b0;
      end
    endcase
  end

  assign reload_now = decide &&
    ((state == cdc_i2c_pkg::ST_PTR && rx_shift == `RESET_CMD_PTR) ||
     (state == cdc_i2c_pkg::ST_GCALL && rx_shift == `GCALL_RESET));
  // invalid or read-only addresses are not stored
  assign reg_wr = decide && state == cdc_i2c_pkg::ST_WDATA &&
                  ptr >= `REG_WR_FIRST && ptr <= `REG_WR_LAST;

  always_comb begin
    read_val = 8'h00;
    if (ptr == `REG_CHIP_IDENTIFICATION) begin
      read_val = CHIP_IDENTIFICATION;
    end else if (ptr >= `REG_SERIAL_FIRST && ptr <= `REG_SERIAL_LAST) begin
      unique case (ptr[1:0])
        2'h3: read_val = SERIAL_NUMBER[31:24];
        2'h0: read_val = SERIAL_NUMBER[23:16];
        2'h1: read_val = SERIAL_NUMBER[15:8];
        2'h2: read_val = SERIAL_NUMBER[7:0];
      endcase
    end else if (ptr[7:5] == 3'h0) begin
      read_val = reg_file[ptr[4:0]];
    end
  end
  assign read_msb = read_val[7];

  genvar gi;
  generate
    for (gi = 0; gi < `REG_FILE_DEPTH; gi++) begin : g_reg
      localparam logic [7:0] DEF =
        (gi == `REG_CAPDAC)   ? `CAPDAC_RESET :
        (gi == `REG_PD_TIMER) ? `PD_TIMER_RESET : `OTHER_RESET;
      always_ff @(posedge link_clk) begin
        if (link_rst || reload_now) begin
          reg_file[gi] <= DEF;
        end else if (reg_wr && ptr[4:0] == 5'(gi)) begin
          reg_file[gi] <= rx_shift;
        end
      end
    end
  endgenerate

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state     <= cdc_i2c_pkg::ST_IDLE;
      after_ack <= cdc_i2c_pkg::ST_IDLE;
      bit_cnt   <= 4'h0;
      rx_shift  <= 8'h00;
      tx_shift  <= 8'h00;
      ptr       <= `PTR_RESET;
      mack_ok   <= 1'b0;
      sda_oe_n  <= 1'b1;
    end else if (stop_det) begin
      state    <= cdc_i2c_pkg::ST_IDLE;
      ptr      <= `PTR_RESET;
      sda_oe_n <= 1'b1;
    end else if (start_det) begin
      state    <= cdc_i2c_pkg::ST_ADDR;
      bit_cnt  <= 4'h0;
      sda_oe_n <= 1'b1;
    end else begin
      unique case (state)
        cdc_i2c_pkg::ST_IDLE: begin
          sda_oe_n <= 1'b1;
        end
        cdc_i2c_pkg::ST_ADDR,
        cdc_i2c_pkg::ST_PTR,
        cdc_i2c_pkg::ST_WDATA,
        cdc_i2c_pkg::ST_GCALL: begin
          if (scl_rise && bit_cnt != `BYTE_BITS) begin
            rx_shift <= {rx_shift[6:0], sda_f};
            bit_cnt  <= bit_cnt + 4'h1;
          end else if (decide) begin
            // pull low across the ninth pulse
            sda_oe_n  <= ~ack_now;
            state     <= ack_now ? cdc_i2c_pkg::ST_ACK
                                 : cdc_i2c_pkg::ST_IDLE;
            after_ack <= next_after;
            bit_cnt   <= 4'h0;
            if (state == cdc_i2c_pkg::ST_PTR) begin
              ptr <= (rx_shift == `RESET_CMD_PTR) ? `PTR_RESET : rx_shift;
            end else if (state == cdc_i2c_pkg::ST_WDATA) begin
              ptr <= ptr + 8'h01;
            end
          end
        end
        cdc_i2c_pkg::ST_ACK: begin
          if (scl_fall) begin
            state   <= after_ack;
            bit_cnt <= 4'h0;
            if (after_ack == cdc_i2c_pkg::ST_TX) begin
              sda_oe_n <= read_val[7];
              tx_shift <= {read_val[6:0], 1'b1};
              bit_cnt  <= 4'h1;
            end else begin
              sda_oe_n <= 1'b1;
            end
          end
        end
        cdc_i2c_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt != `BYTE_BITS) begin
              sda_oe_n <= tx_shift[7];
              tx_shift <= {tx_shift[6:0], 1'b1};
              bit_cnt  <= bit_cnt + 4'h1;
            end else begin
              sda_oe_n <= 1'b1;
              mack_ok  <= 1'b0;
              state    <= cdc_i2c_pkg::ST_MACK;
            end
          end
        end
        cdc_i2c_pkg::ST_MACK: begin
          if (scl_rise) begin
            mack_ok <= ~sda_f;
            if (!sda_f) begin
              ptr <= ptr + 8'h01;
            end
          end else if (scl_fall) begin
            if (mack_ok) begin
              sda_oe_n <= read_val[7];
              tx_shift <= {read_val[6:0], 1'b1};
              bit_cnt  <= 4'h1;
              state    <= cdc_i2c_pkg::ST_TX;
            end else begin
              state <= cdc_i2c_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // crossing toward the core: toggles with held words
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      reload_tgl <= 1'b0;
      wr_tgl     <= 1'b0;
      wr_hold    <= '0;
      link_wait  <= 1'b0;
    end else begin
      if (reload_now) begin
        reload_tgl <= ~reload_tgl;
      end
      // covers the gap until the core busy arrives back
      if (reload_now) begin
        link_wait <= 1'b1;
      end else if (busy_sync) begin
        link_wait <= 1'b0;
      end
      if (reg_wr) begin
        wr_tgl  <= ~wr_tgl;
        wr_hold <= '{addr: ptr, data: rx_shift};
      end
    end
  end

  always_ff @(posedge link_clk) begin
    busy_meta <= reload_busy;
    busy_sync <= busy_meta;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      reload_sync <= 3'h0;
      wr_sync     <= 3'h0;
    end else begin
      reload_sync <= {reload_sync[1:0], reload_tgl};
      wr_sync     <= {wr_sync[1:0], wr_tgl};
    end
  end
  assign reload_edge = reload_sync[2] ^ reload_sync[1];
  assign wr_edge     = wr_sync[2] ^ wr_sync[1];

  always_ff @(posedge clk) begin
    if (reset) begin
      reload_cnt  <= 18'h00000;
      reload_busy <= 1'b0;
    end else if (reload_edge) begin
      reload_cnt  <= 18'(RELOAD_CYCLES - 1);
      reload_busy <= 1'b1;
    end else if (reload_cnt != 18'h00000) begin
      reload_cnt <= reload_cnt - 18'h00001;
    end else begin
      reload_busy <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_valid <= 1'b0;
      wr_word  <= '0;
    end else begin
      wr_valid <= wr_edge;
      if (wr_edge) begin
        wr_word <= wr_hold;
      end
    end
  end

  property p_addr_rd;
    @(posedge link_clk) disable iff (link_rst)
    (decide && state == cdc_i2c_pkg::ST_ADDR && !busy_link &&
     rx_shift == `DEV_ADDR_RD)
    |=> (state == cdc_i2c_pkg::ST_ACK && !sda_oe_n &&
         after_ack == cdc_i2c_pkg::ST_TX);
  endproperty
  a_addr_rd: assert property (p_addr_rd)
    else $error("read addr not acked");

  property p_addr_other;
    @(posedge link_clk) disable iff (link_rst)
    (decide && state == cdc_i2c_pkg::ST_ADDR &&
     rx_shift != `DEV_ADDR_WR && rx_shift != `DEV_ADDR_RD &&
     rx_shift != `GCALL_ADDR)
    |=> (sda_oe_n && state == cdc_i2c_pkg::ST_IDLE);
  endproperty
  a_addr_other: assert property (p_addr_other)
    else $error("foreign ack");

  property p_gcall_ack;
    @(posedge link_clk) disable iff (link_rst)
    (decide && state == cdc_i2c_pkg::ST_ADDR && !busy_link &&
     rx_shift == `GCALL_ADDR)
    |=> (!sda_oe_n && after_ack == cdc_i2c_pkg::ST_GCALL);
  endproperty
  a_gcall_ack: assert property (p_gcall_ack)
    else $error("gcall not acked");

  property p_gcall_other;
    @(posedge link_clk) disable iff (link_rst)
    (decide && state == cdc_i2c_pkg::ST_GCALL && rx_shift != `GCALL_RESET)
    |=> sda_oe_n ##1 sda_oe_n;
  endproperty
  a_gcall_other: assert property (p_gcall_other)
    else $error("gcall acked");

  property p_busy_nack;
    @(posedge link_clk) disable iff (link_rst)
    (decide && state == cdc_i2c_pkg::ST_ADDR && busy_link)
    |=> (sda_oe_n && state == cdc_i2c_pkg::ST_IDLE);
  endproperty
  a_busy_nack: assert property (p_busy_nack)
    else $error("acked in reload");

  property p_stop;
    @(posedge link_clk) disable iff (link_rst)
    stop_det |=> (state == cdc_i2c_pkg::ST_IDLE && ptr == `PTR_RESET &&
                  sda_oe_n);
  endproperty
  a_stop: assert property (p_stop) else $error("stop not handled");

  property p_restart;
    @(posedge link_clk) disable iff (link_rst)
    (start_det && !stop_det)
    |=> (state == cdc_i2c_pkg::ST_ADDR && bit_cnt == 4'h0);
  endproperty
  a_restart: assert property (p_restart) else $error("start missed");

  property p_ptr_load;
    @(posedge link_clk) disable iff (link_rst)
    (decide && state == cdc_i2c_pkg::ST_PTR && rx_shift != `RESET_CMD_PTR)
    |=> (ptr == $past(rx_shift) && !sda_oe_n);
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer not set");

  property p_wr_adv;
    @(posedge link_clk) disable iff (link_rst)
    (decide && state == cdc_i2c_pkg::ST_WDATA)
    |=> (ptr == $past(ptr) + 8'h01 && !sda_oe_n);
  endproperty
  a_wr_adv: assert property (p_wr_adv) else $error("write no advance");

  property p_mack_nack;
    @(posedge link_clk) disable iff (link_rst)
    (state == cdc_i2c_pkg::ST_MACK && scl_rise && sda_f &&
     !start_det && !stop_det)
    |=> (ptr == $past(ptr) && !mack_ok);
  endproperty
  a_mack_nack: assert property (p_mack_nack)
    else $error("nack moved ptr");

  property p_tx_first;
    @(posedge link_clk) disable iff (link_rst)
    (state == cdc_i2c_pkg::ST_ACK && after_ack == cdc_i2c_pkg::ST_TX &&
     scl_fall)
    |=> (sda_oe_n == $past(read_msb) && state == cdc_i2c_pkg::ST_TX);
  endproperty
  a_tx_first: assert property (p_tx_first) else $error("bad first bit");

  property p_reload_busy;
    @(posedge clk) disable iff (reset)
    reload_edge |=> reload_busy ##1 reload_busy;
  endproperty
  a_reload_busy: assert property (p_reload_busy) else $error("no busy");

endmodule
